// ==== rtl/pcm_defines.svh ====
// Offsets, bit positions, reset values and counts of the power/clock mode controller
`ifndef PCM_DEFINES_SVH
`define PCM_DEFINES_SVH
`define PCM_ADDR_W 8
`define PCM_OFF_POWER 8'h00
`define PCM_OFF_SLOWOSC 8'h04
`define PCM_OFF_RADIO 8'h08
`define PCM_OFF_MODEM 8'h0c
`define PCM_OFF_EXTINT 8'h10
`define PCM_OFF_STATUS 8'h14
`define PCM_PWR_IDLE 0
`define PCM_PWR_STOP 1
`define PCM_PWR_GF_LSB 2
`define PCM_SOSC_CLOCK_MODE_SELECT 0
`define PCM_SOSC_PD 1
`define PCM_SOSC_BYPASS 2
`define PCM_SOSC_PD_RESET 1'h1
`define PCM_RADIO_MAIN_OSC_CORE_POWER_DOWN 0
`define PCM_RADIO_MAIN_OSC_BIAS_POWER_DOWN 1
`define PCM_RADIO_RX_EN 2
`define PCM_EXT_EN_LSB 0
`define PCM_EXT_EDGE_LSB 2
`define PCM_EXT_MIN_CYC 4'h8
`define PCM_CSW_EDGES 2'h2
`define PCM_RESTART_ADDR 16'h0000
`define PCM_XTAL_RANGE_RESET 3'h0
`endif

// ==== rtl/pcm_pkg.sv ====
// Types of the power/clock mode controller
package pcm_pkg;
    typedef enum logic [1:0] {PCM_ACTIVE, PCM_IDLE, PCM_STOP} pcm_pmode_t;
    typedef enum logic [1:0] {CSW_RUN, CSW_DRAIN, CSW_HOLD} pcm_csw_t;
endpackage

// ==== rtl/pcm_clk_switch.sv ====
// Glitch-free switch between the main and slow oscillator clocks
`timescale 1ns/1ps
`include "pcm_defines.svh"
module pcm_clk_switch (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic main_osc_input_pin,
    input wire logic slow_osc_input_pin,
    input wire logic sel_slow,
    output logic sys_clk_out,
    output logic on_slow,
    output logic busy
);
    import pcm_pkg::*;

    logic [2:0] m_sync_reg;
    logic [2:0] s_sync_reg;
    logic m_lvl_reg;
    logic s_lvl_reg;
    logic m_prev_reg;
    logic s_prev_reg;
    logic [1:0] sel_sync_reg;
    logic [1:0] edge_cnt_reg;
    pcm_csw_t state_reg;
    logic cur_lvl;
    logic new_rise;

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator pins: three flops, level taken when second and third agree
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            m_sync_reg <= 3'h0;
            s_sync_reg <= 3'h0;
            m_lvl_reg <= 1'b0;
            s_lvl_reg <= 1'b0;
            m_prev_reg <= 1'b0;
            s_prev_reg <= 1'b0;
        end else begin
            m_sync_reg <= {m_sync_reg[1:0], main_osc_input_pin};
            s_sync_reg <= {s_sync_reg[1:0], slow_osc_input_pin};
            if (m_sync_reg[1] == m_sync_reg[2]) begin
                m_lvl_reg <= m_sync_reg[2];
            end
            if (s_sync_reg[1] == s_sync_reg[2]) begin
                s_lvl_reg <= s_sync_reg[2];
            end
            m_prev_reg <= m_lvl_reg;
            s_prev_reg <= s_lvl_reg;
        end
    end

    assign cur_lvl = on_slow ? s_lvl_reg : m_lvl_reg;
    assign new_rise = on_slow ? (m_lvl_reg & ~m_prev_reg) : (s_lvl_reg & ~s_prev_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Handover: finish current high phase, hold low, then count target edges
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_sync_reg <= 2'h0;
            state_reg <= CSW_RUN;
            edge_cnt_reg <= 2'h0;
            on_slow <= 1'b0;
            sys_clk_out <= 1'b0;
            busy <= 1'b0;
        end else begin
            sel_sync_reg <= {sel_sync_reg[0], sel_slow};
            unique case (state_reg)
                CSW_RUN: begin
                    sys_clk_out <= cur_lvl;
                    if (sel_sync_reg[1] != on_slow) begin
                        state_reg <= CSW_DRAIN;
                        busy <= 1'b1;
                    end
                end
                CSW_DRAIN: begin
                    sys_clk_out <= cur_lvl;
                    if (!cur_lvl) begin
                        sys_clk_out <= 1'b0;
                        state_reg <= CSW_HOLD;
                        edge_cnt_reg <= 2'h0;
                    end
                end
                CSW_HOLD: begin
                    sys_clk_out <= 1'b0;
                    if (new_rise) begin
                        edge_cnt_reg <= edge_cnt_reg + 2'h1;
                        if (edge_cnt_reg == `PCM_CSW_EDGES - 2'h1) begin
                            on_slow <= ~on_slow;
                            sys_clk_out <= 1'b1;
                            state_reg <= CSW_RUN;
                            busy <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_hold_low;
        state_reg == CSW_HOLD |-> !sys_clk_out;
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("clock high during handover");

    property p_swap_on_edge;
        !$stable(on_slow) |-> $past(state_reg) == CSW_HOLD && $past(new_rise) && sys_clk_out;
    endproperty
    a_swap_on_edge: assert property (p_swap_on_edge)
        else $error("source swap off edge");

    c_to_slow: cover property ($rose(on_slow));
    c_to_main: cover property ($fell(on_slow));
endmodule

// ==== rtl/pcm_power_clock_ctrl.sv ====
// Power and clock mode controller with APB register access
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`include "pcm_defines.svh"
module pcm_power_clock_ctrl (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PCM_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic core_instr_done,
    input wire logic irq_pending,
    input wire logic reset_request,
    input wire logic adc_on,
    input wire logic adc_threshold_wake,
    input wire logic [1:0] ext_int_pin_n,
    input wire logic main_osc_input_pin,
    input wire logic slow_osc_input_pin,
    output logic core_clk_en,
    output logic periph_clk_en,
    output logic adc_clk_en,
    output logic core_reset,
    output logic [15:0] restart_addr,
    output logic [1:0] ext_irq,
    output logic sys_clk_out,
    output logic main_osc_enable,
    output logic slow_osc_enable,
    output logic slow_osc_bypass,
    output logic radio_rx_enable,
    output logic [2:0] crystal_range_field,
    output pcm_pkg::pcm_pmode_t power_mode
);
    import pcm_pkg::*;

    logic idle_bit_reg;
    logic stop_bit_reg;
    logic [1:0] gf_reg;
    logic clock_mode_select_reg;
    logic sosc_pd_reg;
    logic bypass_reg;
    logic main_osc_core_power_down_reg;
    logic main_osc_bias_power_down_reg;
    logic rx_req_reg;
    logic [1:0] ext_en_reg;
    logic [1:0] ext_edge_reg;
    logic [1:0][2:0] ext_sync_reg;
    logic [1:0] ext_lvl_reg;
    logic [1:0][3:0] ext_cnt_reg;
    logic wake_rst_reg;
    logic soft_rst;
    logic wr_en;
    logic [31:0] rd_data;
    logic on_slow;
    logic csw_busy;

    function automatic logic is_mapped(input logic [`PCM_ADDR_W-1:0] a);
        is_mapped = (a == `PCM_OFF_POWER) || (a == `PCM_OFF_SLOWOSC) ||
                    (a == `PCM_OFF_RADIO) || (a == `PCM_OFF_MODEM) ||
                    (a == `PCM_OFF_EXTINT) || (a == `PCM_OFF_STATUS);
    endfunction

    function automatic logic wr_hit(input logic [`PCM_ADDR_W-1:0] off);
        wr_hit = wr_en && (paddr == off);
    endfunction

    // Any reset source, including a converter wake, restarts the registers and power mode, but not the clock switch
    assign soft_rst = reset_request | wake_rst_reg;
    assign wr_en = psel & penable & pready & pwrite;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states, error on unmapped offsets
    always_comb begin
        rd_data = 32'h0;
        unique case (paddr)
            `PCM_OFF_POWER: rd_data = {28'h0, gf_reg, stop_bit_reg, idle_bit_reg};
            `PCM_OFF_SLOWOSC: rd_data = {29'h0, bypass_reg, sosc_pd_reg, clock_mode_select_reg};
            `PCM_OFF_RADIO: rd_data = {29'h0, rx_req_reg, main_osc_bias_power_down_reg, main_osc_core_power_down_reg};
            `PCM_OFF_MODEM: rd_data = {29'h0, crystal_range_field};
            `PCM_OFF_EXTINT: rd_data = {28'h0, ext_edge_reg, ext_en_reg};
            `PCM_OFF_STATUS: rd_data = {26'h0, ext_irq, main_osc_enable, csw_busy,
                                        on_slow, power_mode == PCM_IDLE};
            default: rd_data = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~is_mapped(paddr);
            if (psel && !penable) begin
                prdata <= rd_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gf_reg <= 2'h0;
            clock_mode_select_reg <= 1'b0;
            sosc_pd_reg <= `PCM_SOSC_PD_RESET;
            bypass_reg <= 1'b0;
            main_osc_core_power_down_reg <= 1'b0;
            main_osc_bias_power_down_reg <= 1'b0;
            rx_req_reg <= 1'b0;
            crystal_range_field <= `PCM_XTAL_RANGE_RESET;
            ext_en_reg <= 2'h0;
            ext_edge_reg <= 2'h0;
        end else if (soft_rst) begin
            gf_reg <= 2'h0;
            clock_mode_select_reg <= 1'b0;
            sosc_pd_reg <= `PCM_SOSC_PD_RESET;
            bypass_reg <= 1'b0;
            main_osc_core_power_down_reg <= 1'b0;
            main_osc_bias_power_down_reg <= 1'b0;
            rx_req_reg <= 1'b0;
            crystal_range_field <= `PCM_XTAL_RANGE_RESET;
            ext_en_reg <= 2'h0;
            ext_edge_reg <= 2'h0;
        end else begin
            if (wr_hit(`PCM_OFF_POWER)) begin
                gf_reg <= pwdata[`PCM_PWR_GF_LSB +: 2];
            end
            if (wr_hit(`PCM_OFF_SLOWOSC)) begin
                clock_mode_select_reg <= pwdata[`PCM_SOSC_CLOCK_MODE_SELECT];
                sosc_pd_reg <= pwdata[`PCM_SOSC_PD];
                bypass_reg <= pwdata[`PCM_SOSC_BYPASS];
            end
            if (wr_hit(`PCM_OFF_RADIO)) begin
                main_osc_core_power_down_reg <= pwdata[`PCM_RADIO_MAIN_OSC_CORE_POWER_DOWN];
                main_osc_bias_power_down_reg <= pwdata[`PCM_RADIO_MAIN_OSC_BIAS_POWER_DOWN];
                rx_req_reg <= pwdata[`PCM_RADIO_RX_EN];
            end
            if (wr_hit(`PCM_OFF_MODEM)) begin
                crystal_range_field <= pwdata[2:0];
            end
            if (wr_hit(`PCM_OFF_EXTINT)) begin
                ext_en_reg <= pwdata[`PCM_EXT_EN_LSB +: 2];
                ext_edge_reg <= pwdata[`PCM_EXT_EDGE_LSB +: 2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power mode sequencing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            power_mode <= PCM_ACTIVE;
            idle_bit_reg <= 1'b0;
            stop_bit_reg <= 1'b0;
        end else if (soft_rst) begin
            power_mode <= PCM_ACTIVE;
            idle_bit_reg <= 1'b0;
            stop_bit_reg <= 1'b0;
        end else begin
            unique case (power_mode)
                PCM_ACTIVE: begin
                    if (wr_hit(`PCM_OFF_POWER)) begin
                        idle_bit_reg <= pwdata[`PCM_PWR_IDLE];
                        stop_bit_reg <= pwdata[`PCM_PWR_STOP];
                    end else if (core_instr_done && stop_bit_reg) begin
                        power_mode <= PCM_STOP;
                    end else if (core_instr_done && idle_bit_reg) begin
                        power_mode <= PCM_IDLE;
                    end
                end
                PCM_IDLE: begin
                    if (irq_pending || (|ext_irq)) begin
                        idle_bit_reg <= 1'b0;
                        power_mode <= PCM_ACTIVE;
                    end
                end
                PCM_STOP: begin
                    power_mode <= PCM_STOP;
                end
            endcase
        end
    end

    // Converter threshold crossing in power-down turns into a reset pulse
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_rst_reg <= 1'b0;
        end else begin
            wake_rst_reg <= ~soft_rst & (power_mode == PCM_STOP) & adc_on &
                            adc_threshold_wake;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_clk_en <= 1'b1;
            periph_clk_en <= 1'b1;
            adc_clk_en <= 1'b1;
            core_reset <= 1'b0;
            restart_addr <= `PCM_RESTART_ADDR;
        end else begin
            core_clk_en <= (power_mode == PCM_ACTIVE) | soft_rst;
            periph_clk_en <= (power_mode != PCM_STOP) | soft_rst;
            adc_clk_en <= 1'b1;
            core_reset <= soft_rst;
            restart_addr <= `PCM_RESTART_ADDR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // External interrupt pins: synchronise, then require a long enough pulse
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_sync_reg <= '0;
            ext_lvl_reg <= 2'h0;
            ext_cnt_reg <= '0;
            ext_irq <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                ext_sync_reg[i] <= {ext_sync_reg[i][1:0], ~ext_int_pin_n[i]};
                if (ext_sync_reg[i][1] == ext_sync_reg[i][2]) begin
                    ext_lvl_reg[i] <= ext_sync_reg[i][2];
                end
                if (!ext_lvl_reg[i]) begin
                    ext_cnt_reg[i] <= 4'h0;
                end else if (ext_cnt_reg[i] <= `PCM_EXT_MIN_CYC) begin
                    ext_cnt_reg[i] <= ext_cnt_reg[i] + 4'h1;
                end
                // Edge mode fires once per pulse, level mode while held
                ext_irq[i] <= ext_en_reg[i] & ext_lvl_reg[i] & ~soft_rst &
                              (ext_edge_reg[i] ? (ext_cnt_reg[i] == `PCM_EXT_MIN_CYC) :
                               (ext_cnt_reg[i] >= `PCM_EXT_MIN_CYC));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator enables and radio receive gate
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            main_osc_enable <= 1'b1;
            slow_osc_enable <= 1'b0;
            slow_osc_bypass <= 1'b0;
            radio_rx_enable <= 1'b0;
        end else begin
            // Stop bit is not a term here: oscillators stay as set
            main_osc_enable <= ~(main_osc_core_power_down_reg & main_osc_bias_power_down_reg & clock_mode_select_reg & on_slow);
            slow_osc_enable <= ~sosc_pd_reg & ~bypass_reg;
            slow_osc_bypass <= bypass_reg;
            radio_rx_enable <= rx_req_reg & ~clock_mode_select_reg & ~on_slow;
        end
    end

    pcm_clk_switch u_clk_switch (
        .clk(clk),
        .arst_n(arst_n),
        .main_osc_input_pin(main_osc_input_pin),
        .slow_osc_input_pin(slow_osc_input_pin),
        .sel_slow(clock_mode_select_reg),
        .sys_clk_out(sys_clk_out),
        .on_slow(on_slow),
        .busy(csw_busy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_idle_after_done;
        $rose(power_mode == PCM_IDLE) |-> $past(core_instr_done) && $past(idle_bit_reg);
    endproperty
    a_idle_after_done: assert property (p_idle_after_done)
        else $error("idle before done");

    property p_idle_halts;
        power_mode == PCM_IDLE && !soft_rst |=> !core_clk_en && periph_clk_en;
    endproperty
    a_idle_halts: assert property (p_idle_halts) else $error("idle clock gating wrong");

    property p_irq_wakes;
        power_mode == PCM_IDLE && irq_pending && !soft_rst
            |=> power_mode == PCM_ACTIVE && !idle_bit_reg ##1 core_clk_en;
    endproperty
    a_irq_wakes: assert property (p_irq_wakes)
        else $error("interrupt did not end idle");

    property p_reset_restart;
        soft_rst |=> core_reset && restart_addr == `PCM_RESTART_ADDR && power_mode == PCM_ACTIVE;
    endproperty
    a_reset_restart: assert property (p_reset_restart)
        else $error("reset restart wrong");

    property p_stop_gates;
        power_mode == PCM_STOP && !soft_rst |=> !core_clk_en && !periph_clk_en && adc_clk_en;
    endproperty
    a_stop_gates: assert property (p_stop_gates) else $error("stop gating wrong");

    property p_stop_holds;
        power_mode == PCM_STOP && !soft_rst && (irq_pending || (|ext_irq))
            |=> power_mode == PCM_STOP;
    endproperty
    a_stop_holds: assert property (p_stop_holds) else $error("interrupt left stop");

    property p_adc_wake;
        power_mode == PCM_STOP && adc_on && adc_threshold_wake && !soft_rst
            |-> ##2 core_reset;
    endproperty
    a_adc_wake: assert property (p_adc_wake) else $error("no converter wake reset");

    property p_ext_long_pulse;
        ext_en_reg[0] && ext_lvl_reg[0] && ext_cnt_reg[0] == `PCM_EXT_MIN_CYC && !soft_rst
            |=> ext_irq[0];
    endproperty
    a_ext_long_pulse: assert property (p_ext_long_pulse)
        else $error("long pulse missed");

    property p_main_osc_stop;
        main_osc_core_power_down_reg && main_osc_bias_power_down_reg && clock_mode_select_reg && on_slow |=> !main_osc_enable;
    endproperty
    a_main_osc_stop: assert property (p_main_osc_stop)
        else $error("main osc not stopped");

    property p_rx_blocked;
        clock_mode_select_reg || on_slow |=> !radio_rx_enable;
    endproperty
    a_rx_blocked: assert property (p_rx_blocked) else $error("receiver on slow clock");

    c_idle_wake: cover property (power_mode == PCM_IDLE ##1 power_mode == PCM_ACTIVE);
    c_stop_wake: cover property (power_mode == PCM_STOP ##1 wake_rst_reg);
    c_ext_irq: cover property ($rose(ext_irq[1]));
endmodule

// ==== tb/pcm_core_model.sv ====
// Behavioural core model: retires one instruction every fourth clocked cycle
`timescale 1ns/1ps
module pcm_core_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic core_clk_en,
    output logic core_instr_done
);
    logic [1:0] phase_reg;
    // Halted core retires nothing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg <= 2'h0;
            core_instr_done <= 1'b0;
        end else begin
            phase_reg <= phase_reg + {1'b0, core_clk_en};
            core_instr_done <= core_clk_en && (phase_reg == 2'h3);
        end
    end
endmodule

// ==== tb/power_clock_mode_control_test.sv ====
// Register-level test of the power and clock mode controller
`timescale 1ns/1ps
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin err_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, x); end end
module power_clock_mode_control_test;
    import pcm_pkg::*;
    logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic done, irq_pending = 0, reset_request = 0, adc_on = 0, adc_wake = 0, e;
    logic [1:0] ext_n = 2'h3, ext_irq;
    logic mosc = 0, sosc = 0, sclk_q = 0, cce, pce, ace, creset, moe, soe, byp, rxe, sclk;
    logic [15:0] raddr;
    logic [2:0] xr;
    pcm_pmode_t pm;
    int err_count = 0, cmp_count = 0, cyc = 0, run_len = 0, last_len = 0;
    initial forever #12.5 clk = ~clk;
    always #50 mosc = ~mosc;
    always #200 sosc = ~sosc;
    pcm_power_clock_ctrl u_pcm_power_clock_ctrl (.clk(clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_instr_done(done),
        .irq_pending(irq_pending), .reset_request(reset_request), .adc_on(adc_on),
        .adc_threshold_wake(adc_wake), .ext_int_pin_n(ext_n), .main_osc_input_pin(mosc),
        .slow_osc_input_pin(sosc), .core_clk_en(cce), .periph_clk_en(pce),
        .adc_clk_en(ace), .core_reset(creset), .restart_addr(raddr), .ext_irq(ext_irq),
        .sys_clk_out(sclk), .main_osc_enable(moe), .slow_osc_enable(soe),
        .slow_osc_bypass(byp), .radio_rx_enable(rxe), .crystal_range_field(xr),
        .power_mode(pm));
    pcm_core_model u_pcm_core_model (.clk(clk), .arst_n(arst_n), .core_clk_en(cce),
        .core_instr_done(done));
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        wt(2);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(r & m, x)
    endtask
    task automatic till(input pcm_pmode_t m);
        for (int i = 0; i < 60 && pm !== m; i++) @(posedge clk);
        `CHK(pm, m)
    endtask
    task automatic till_slow(input logic v);
        for (int i = 0; i < 100; i++) begin
            apb(1'b0, 8'h14, 32'h0);
            if (r[1] === v) break;
        end
        `CHK(r[1], v)
    endtask
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            print_verdict;
        end
    end
    // Sys clock phases: none shorter than two cycles, last_len keeps the latest
    always @(posedge clk) begin
        if (arst_n && sclk !== sclk_q) begin
            `CHK(run_len >= 2, 1'b1)
            last_len = run_len;
            run_len = 1;
        end else begin
            run_len++;
        end
        sclk_q = sclk;
    end
    initial begin
        wt(8);
        arst_n <= 1'b1;
        wt(1);
        `CHK({cce, moe, soe}, 3'h6)
        rd(8'h04, 32'h7, 32'h2);
        `CHK(raddr, 16'h0000)
        apb(1'b1, 8'h40, 32'h1);
        `CHK(e, 1'b1)
        wr(8'h0c, 32'h5);
        `CHK(xr, 3'h5)
        wr(8'h10, 32'h1);
        wr(8'h00, 32'h1);
        till(PCM_IDLE);
        wt(2);
        `CHK({cce, pce}, 2'h1)
        ext_n <= 2'h2;
        wt(5);
        ext_n <= 2'h3;
        wt(15);
        `CHK(pm, PCM_IDLE)
        ext_n <= 2'h2;
        wt(16);
        `CHK(ext_irq[0], 1'b1)
        ext_n <= 2'h3;
        till(PCM_ACTIVE);
        rd(8'h00, 32'h1, 32'h0);
        wr(8'h00, 32'h1);
        till(PCM_IDLE);
        irq_pending <= 1'b1;
        till(PCM_ACTIVE);
        irq_pending <= 1'b0;
        wr(8'h00, 32'h1);
        till(PCM_IDLE);
        reset_request <= 1'b1;
        wt(1);
        reset_request <= 1'b0;
        wt(1);
        `CHK(creset, 1'b1)
        wt(1);
        `CHK({pm, xr}, {PCM_ACTIVE, 3'h0})
        wr(8'h10, 32'ha);
        wr(8'h00, 32'h1);
        till(PCM_IDLE);
        ext_n <= 2'h1;
        till(PCM_ACTIVE);
        wt(4);
        `CHK(ext_irq, 2'h0)
        ext_n <= 2'h3;
        wr(8'h10, 32'h1);
        wr(8'h00, 32'h2);
        till(PCM_STOP);
        wt(2);
        `CHK({cce, pce, ace}, 3'h1)
        `CHK(moe, 1'b1)
        irq_pending <= 1'b1;
        ext_n <= 2'h2;
        wt(20);
        `CHK(pm, PCM_STOP)
        irq_pending <= 1'b0;
        ext_n <= 2'h3;
        adc_on <= 1'b1;
        adc_wake <= 1'b1;
        till(PCM_ACTIVE);
        adc_on <= 1'b0;
        adc_wake <= 1'b0;
        wr(8'h04, 32'h0);
        `CHK(soe, 1'b1)
        wr(8'h04, 32'h1);
        till_slow(1'b1);
        wt(40);
        `CHK(last_len, 8)
        wr(8'h08, 32'h4);
        `CHK(rxe, 1'b0)
        wr(8'h08, 32'h3);
        `CHK(moe, 1'b0)
        wr(8'h08, 32'h0);
        wt(10);
        wr(8'h04, 32'h0);
        till_slow(1'b0);
        wt(10);
        `CHK(last_len, 2)
        wr(8'h08, 32'h4);
        `CHK(rxe, 1'b1)
        wr(8'h04, 32'h6);
        `CHK(byp, 1'b1)
        print_verdict;
    end
endmodule
